/* File: rtl/hsw_params.svh */
// constants for the high-side switch fault control block
// assumes a 20 MHz core clock; included by bare name
`ifndef HSW_PARAMS_SVH
`define HSW_PARAMS_SVH

`define HSW_CLK_MHZ         20
// high-side status bit positions
`define HSW_SR_CL_BIT       0
`define HSW_SR_OL_BIT       1
// interrupt source code for a high-side event
`define HSW_ISR_HS_CODE     4'h2
`define HSW_ISR_NONE        4'h0
// control register bit positions
`define HSW_CR_EN_BIT       0
`define HSW_CR_PWM_BIT      1
// analog comparator inputs pass this many synchroniser flops, then one filter flop
`define HSW_SYNC_STAGES     3

`endif

/* File: rtl/hsw_pin_sync.sv */
// three-flop synchronisers for the asynchronous pins and comparators
// a change is accepted only when the second and third flops agree
`timescale 1ns/1ps
`include "hsw_params.svh"
module hsw_pin_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pwmPin,
  input  wire logic openLoadCmp,
  input  wire logic curLimitCmp,
  input  wire logic overTempCmp,
  input  wire logic highVoltCmp,
  hsw_sync_if.src   syncOut
);

  localparam int N = 5;

  logic [N-1:0] rawIn;
  logic [N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [N-1:0] s1_next, s2_next, s3_next, lvl_next;

  assign rawIn = {highVoltCmp, overTempCmp, curLimitCmp,
                  openLoadCmp, pwmPin};

  always_comb begin
    s1_next  = rawIn;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    lvl_next = lvl_reg;
    for (int i = 0; i < N; i++) begin
      // filters a metastable-resolved single-cycle blip
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= 5'h00;
      s2_reg  <= 5'h00;
      s3_reg  <= 5'h00;
      lvl_reg <= 5'h00;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign syncOut.pwm      = lvl_reg[0];
  assign syncOut.openLoad = lvl_reg[1];
  assign syncOut.curLimit = lvl_reg[2];
  assign syncOut.overTemp = lvl_reg[3];
  assign syncOut.highVolt = lvl_reg[4];

endmodule // hsw_pin_sync

/* File: rtl/hsw_pkg.sv */
// types for the high-side switch fault control block
// no dependencies
package hsw_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_NORMAL_REQ,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESET
  } hsw_mode_e;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_SHUT_OT,
    SW_SHUT_HV
  } hsw_state_e;

endpackage

/* File: rtl/hsw_switch_ctrl.sv */
// high-side switch control: on/off, pwm gating, fault flags and shutdown
// assumes analog comparators and the pwm pin are asynchronous to clk,
// and that the host presents control writes as one-cycle strobes
//
// Notes on behaviour
// - output follows the switch-enable control bit
// - enable plus pwm gate: output follows pwm
// - open-load flag bit 1 while current low
// - current limit keeps output on, flag bit 0
// - overtemperature shuts output, latches source code 0010
// - thermal shutdown sets both status flags
// - irq low for overtemperature only when masked in
// - masked source: irq high, source not set
// - after thermal shutdown, only a write re-enables
// - high-voltage shutdown when enabled and present
// - after high-voltage shutdown, write re-enables when clear
// - output may stay on in sleep, stop
// - fault interrupts only in normal, request, stop
`timescale 1ns/1ps
`include "hsw_params.svh"
module hsw_switch_ctrl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // control register write strobe and data
  input  wire logic        ctrlWrite,
  input  wire logic [1:0]  ctrlWriteData,
  // mode control and interrupt mask bits
  input  wire logic        highVoltShutdownEnable,
  input  wire logic        highSideIrqMaskBit,
  input  wire logic [2:0]  opMode,
  // interrupt source acknowledge from the host side
  input  wire logic        irqSourceClear,
  // asynchronous inputs
  input  wire logic        pwmInputPin,
  input  wire logic        openLoadCmp,
  input  wire logic        curLimitCmp,
  input  wire logic        overTempCmp,
  input  wire logic        highVoltCmp,
  // outputs
  output logic             highSideOutputEnable,
  output logic [1:0]       highSideControlReg,
  output logic [1:0]       highSideStatusReg,
  output logic [3:0]       interruptSourceReg,
  output logic             irqPin_n,
  output logic             shutdownActive
);

  hsw_sync_if syncBus ();

  hsw_pin_sync u_sync (
    .clk         (clk),
    .reset_n     (reset_n),
    .pwmPin      (pwmInputPin),
    .openLoadCmp (openLoadCmp),
    .curLimitCmp (curLimitCmp),
    .overTempCmp (overTempCmp),
    .highVoltCmp (highVoltCmp),
    .syncOut     (syncBus.src)
  );

  hsw_pkg::hsw_mode_e  modeNow;
  assign modeNow = hsw_pkg::hsw_mode_e'(opMode);

  function automatic logic irqModeOk(input hsw_pkg::hsw_mode_e m);
    irqModeOk = (m == hsw_pkg::MODE_NORMAL) ||
                (m == hsw_pkg::MODE_NORMAL_REQ) ||
                (m == hsw_pkg::MODE_STOP);
  endfunction

  // ---- control register and shutdown state ----
  hsw_pkg::hsw_state_e state_reg, state_next;
  logic [1:0]          ctrl_reg, ctrl_next;

  always_comb begin
    state_next = state_reg;
    ctrl_next  = ctrl_reg;
    if (ctrlWrite) begin
      ctrl_next = ctrlWriteData;
    end
    unique case (state_reg)
      hsw_pkg::SW_RUN: begin
        // overtemperature takes precedence for the source report
        if (syncBus.overTemp) begin
          state_next = hsw_pkg::SW_SHUT_OT;
        end else if (highVoltShutdownEnable && syncBus.highVolt) begin
          state_next = hsw_pkg::SW_SHUT_HV;
        end
      end
      hsw_pkg::SW_SHUT_OT: begin
        // a write while still hot is stored but does not restart
        if (ctrlWrite && !syncBus.overTemp) begin
          state_next = hsw_pkg::SW_RUN;
        end
      end
      hsw_pkg::SW_SHUT_HV: begin
        if (syncBus.overTemp) begin
          state_next = hsw_pkg::SW_SHUT_OT;
        end else if (ctrlWrite && !syncBus.highVolt) begin
          state_next = hsw_pkg::SW_RUN;
        end
      end
      default: begin
        // the unused code parks the switch off until the host writes
        state_next = hsw_pkg::SW_SHUT_HV;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= hsw_pkg::SW_RUN;
      ctrl_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  // ---- output drive ----
  logic outOn_reg, outOn_next;

  always_comb begin
    outOn_next = 1'b0;
    if (state_reg == hsw_pkg::SW_RUN) begin
      // mode is not consulted: the switch stays usable in sleep and stop
      if (ctrl_reg[`HSW_CR_EN_BIT]) begin
        if (ctrl_reg[`HSW_CR_PWM_BIT]) begin
          outOn_next = syncBus.pwm;
        end else begin
          outOn_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outOn_reg <= 1'b0;
    end else begin
      outOn_reg <= outOn_next;
    end
  end

  // ---- status flags ----
  logic [1:0] status_reg, status_next;

  always_comb begin
    status_next = 2'h0;
    if (state_reg == hsw_pkg::SW_SHUT_OT) begin
      status_next = 2'h3;
    end else begin
      // flags only mean something while the switch drives a load
      status_next[`HSW_SR_OL_BIT] = outOn_reg && syncBus.openLoad;
      status_next[`HSW_SR_CL_BIT] = outOn_reg && syncBus.curLimit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // ---- interrupt source and request ----
  logic [3:0] isr_reg, isr_next;
  logic       irqN_reg, irqN_next;
  logic       otEvent;

  // entry from run or from high-voltage shutdown is a new thermal event
  assign otEvent = (state_reg != hsw_pkg::SW_SHUT_OT) &&
                   (state_next == hsw_pkg::SW_SHUT_OT);

  always_comb begin
    isr_next = isr_reg;
    if (irqSourceClear) begin
      isr_next = `HSW_ISR_NONE;
    end
    // event wins over a clear in the same cycle
    if (otEvent && highSideIrqMaskBit && irqModeOk(modeNow)) begin
      isr_next = `HSW_ISR_HS_CODE;
    end
    irqN_next = (isr_next == `HSW_ISR_NONE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      isr_reg  <= `HSW_ISR_NONE;
      irqN_reg <= 1'b1;
    end else begin
      isr_reg  <= isr_next;
      irqN_reg <= irqN_next;
    end
  end

  // ---- shadow outputs, each from a flop ----
  logic shut_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shut_reg <= 1'b0;
    end else begin
      shut_reg <= (state_next != hsw_pkg::SW_RUN);
    end
  end

  assign highSideOutputEnable = outOn_reg;
  assign highSideControlReg   = ctrl_reg;
  assign highSideStatusReg    = status_reg;
  assign interruptSourceReg   = isr_reg;
  assign irqPin_n             = irqN_reg;
  assign shutdownActive       = shut_reg;

endmodule // hsw_switch_ctrl

/* File: rtl/hsw_sync_if.sv */
// carries the synchronised pin levels from the input stage to the core
// all signals on clk
`timescale 1ns/1ps
interface hsw_sync_if;
  logic pwm;
  logic openLoad;
  logic curLimit;
  logic overTemp;
  logic highVolt;

  modport src (output pwm, output openLoad, output curLimit,
               output overTemp, output highVolt);
  modport dst (input pwm, input openLoad, input curLimit,
               input overTemp, input highVolt);
endinterface

/* File: verification/hsw_host_model.sv */
// host side: control writes and interrupt acknowledge
// drives on rising edges of the shared clk
`timescale 1ns/1ps
module hsw_host_model (
  input  wire logic       clk,
  output logic            ctrlWrite,
  output logic [1:0]      ctrlWriteData,
  output logic            irqSourceClear
);
  initial begin
    ctrlWrite = 1'h0;
    ctrlWriteData = 2'h0;
    irqSourceClear = 1'h0;
  end
  // the only way back on after a shutdown is this write
  task automatic writeCtrl(input logic [1:0] d);
    @(posedge clk);
    ctrlWrite <= 1'h1;
    ctrlWriteData <= d;
    @(posedge clk);
    ctrlWrite <= 1'h0;
    ctrlWriteData <= ~d;
  endtask
  task automatic clearIrq();
    @(posedge clk);
    irqSourceClear <= 1'h1;
    @(posedge clk);
    irqSourceClear <= 1'h0;
  endtask
endmodule // hsw_host_model

/* File: verification/hsw_switch_ctrl_asserts.sv */
// port checker for the switch control
// bound to hsw_switch_ctrl; one clock domain
`timescale 1ns/1ps
module hsw_switch_ctrl_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       ctrlWrite,
  input wire logic [1:0] ctrlWriteData,
  input wire logic       highVoltShutdownEnable,
  input wire logic       highSideIrqMaskBit,
  input wire logic [2:0] opMode,
  input wire logic       overTempCmp,
  input wire logic       highVoltCmp,
  input wire logic       highSideOutputEnable,
  input wire logic [1:0] highSideControlReg,
  input wire logic [1:0] highSideStatusReg,
  input wire logic [3:0] interruptSourceReg,
  input wire logic       irqPin_n,
  input wire logic       shutdownActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // 8 cycles covers the pin synchroniser plus the shutdown steps
  sequence otHeld; overTempCmp [*8]; endsequence
  sequence hvHeld; (highVoltCmp && highVoltShutdownEnable) [*8]; endsequence
  sequence offWrite; ctrlWrite && !ctrlWriteData[0] ##1 !ctrlWrite; endsequence
  AST_CTRL_COPY: assert property (
    ctrlWrite |=> highSideControlReg == $past(ctrlWriteData))
    else $error("control copy wrong");
  AST_WRITE_OFF: assert property (
    offWrite |=> !highSideOutputEnable) else $error("output not off");
  AST_OT_SHUT: assert property (
    otHeld |-> !highSideOutputEnable && shutdownActive
      && highSideStatusReg == 2'h3) else $error("no thermal shutdown");
  AST_HV_SHUT: assert property (
    hvHeld |-> !highSideOutputEnable && shutdownActive)
    else $error("no high-voltage shutdown");
  AST_ISR_MASK: assert property (
    $rose(interruptSourceReg[1]) |-> $past(highSideIrqMaskBit) && !irqPin_n)
    else $error("source set while masked");
  AST_IRQ_MODE: assert property (
    $fell(irqPin_n) |-> $past(opMode) < 3'h3) else $error("irq in bad mode");
  AST_HOLD: assert property (
    overTempCmp [*5] ##0 shutdownActive |=> shutdownActive)
    else $error("shutdown left during fault");
  AST_RELEASE: assert property (
    $fell(shutdownActive) |-> $past(ctrlWrite) || $past(ctrlWrite, 2))
    else $error("shutdown left without write");
endmodule // hsw_switch_ctrl_asserts

bind hsw_switch_ctrl hsw_switch_ctrl_asserts chkU (.*);

/* File: verification/hsw_switch_ctrl_test.sv */
// self-checking bench for the switch control
// host model makes writes; bench drives pins and comparators
`timescale 1ns/1ps
module hsw_switch_ctrl_test;
  logic       clk = 1'h0;
  logic       reset_n, pwmInputPin, openLoadCmp, curLimitCmp, overTempCmp;
  logic       highVoltCmp, highVoltShutdownEnable, highSideIrqMaskBit;
  logic       ctrlWrite, irqSourceClear, highSideOutputEnable, irqPin_n;
  logic       shutdownActive;
  logic [1:0] ctrlWriteData, highSideControlReg, highSideStatusReg;
  logic [2:0] opMode;
  logic [3:0] interruptSourceReg;
  // rows: write data, pwm pin, expected output
  logic [3:0] rows [5] = '{4'h2, 4'h5, 4'hF, 4'hC, 4'hA};
  int         n_fail = 0;
  int         checks_done = 0;
  hsw_switch_ctrl dut_u (.*);
  hsw_host_model  hostU (.*);
  initial forever #25 clk = ~clk;
  // lands 1 ns after the edge so registered outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [3:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fault(input logic m, input logic [2:0] md,
                       input logic [3:0] e);
    @(posedge clk) highSideIrqMaskBit <= m;
    opMode <= md;
    hostU.writeCtrl(2'h1);
    w(8);
    chk("on", highSideOutputEnable, 4'h1);
    @(posedge clk) overTempCmp <= 1'h1;
    w(10);
    chk("otOut", highSideOutputEnable, 4'h0);
    chk("otStat", highSideStatusReg, 4'h3);
    chk("otShut", shutdownActive, 4'h1);
    chk("isr", interruptSourceReg, e);
    chk("irqN", irqPin_n, {3'h0, e == 4'h0});
    hostU.writeCtrl(2'h1);
    w(4);
    chk("held", highSideOutputEnable, 4'h0);
    chk("heldIsr", interruptSourceReg, e);
    chk("heldStat", highSideStatusReg, 4'h3);
    @(posedge clk) overTempCmp <= 1'h0;
    w(8);
    hostU.writeCtrl(2'h1);
    w(4);
    chk("reOn", highSideOutputEnable, 4'h1);
    chk("reShut", shutdownActive, 4'h0);
    hostU.clearIrq();
    w(2);
    chk("irqOff", irqPin_n, 4'h1);
  endtask
  initial begin
    {reset_n, pwmInputPin, openLoadCmp, curLimitCmp, overTempCmp} = '0;
    {highVoltCmp, highVoltShutdownEnable, highSideIrqMaskBit} = '0;
    opMode = 3'h0;
    w(9);
    @(posedge clk) reset_n <= 1'h1;
    w(1);
    chk("rstIrq", irqPin_n, 4'h1);
    chk("rstOut", highSideOutputEnable, 4'h0);
    chk("rstIsr", interruptSourceReg, 4'h0);
    foreach (rows[i]) begin
      @(posedge clk) pwmInputPin <= rows[i][1];
      hostU.writeCtrl(rows[i][3:2]);
      w(8);
      chk("row", highSideOutputEnable, {3'h0, rows[i][0]});
      chk("rowCtrl", highSideControlReg, {2'h0, rows[i][3:2]});
    end
    hostU.writeCtrl(2'h1);
    @(posedge clk) openLoadCmp <= 1'h1;
    w(8);
    chk("openLoad", highSideStatusReg, 4'h2);
    @(posedge clk) {openLoadCmp, curLimitCmp} <= 2'h1;
    w(8);
    chk("curLim", highSideStatusReg, 4'h1);
    chk("limOn", highSideOutputEnable, 4'h1);
    @(posedge clk) curLimitCmp <= 1'h0;
    fault(1'h1, 3'h0, 4'h2);
    fault(1'h0, 3'h1, 4'h0);
    fault(1'h1, 3'h3, 4'h0);
    fault(1'h1, 3'h2, 4'h2);
    @(posedge clk) highVoltCmp <= 1'h1;
    w(10);
    chk("hvIgnored", highSideOutputEnable, 4'h1);
    @(posedge clk) highVoltShutdownEnable <= 1'h1;
    w(10);
    chk("hvOff", highSideOutputEnable, 4'h0);
    chk("hvShut", shutdownActive, 4'h1);
    chk("hvIsr", interruptSourceReg, 4'h0);
    hostU.writeCtrl(2'h1);
    w(4);
    chk("hvHeld", highSideOutputEnable, 4'h0);
    // overtemperature during a high-voltage shutdown is still reported
    @(posedge clk) overTempCmp <= 1'h1;
    w(8);
    chk("hvToOt", highSideStatusReg, 4'h3);
    chk("hvToOtIsr", interruptSourceReg, 4'h2);
    @(posedge clk) overTempCmp <= 1'h0;
    w(8);
    @(posedge clk) highVoltCmp <= 1'h0;
    w(8);
    hostU.writeCtrl(2'h1);
    w(4);
    chk("hvOn", highSideOutputEnable, 4'h1);
    // reset in mid-run drops the switch until the host writes again
    @(posedge clk) reset_n <= 1'h0;
    w(1);
    chk("midOut", highSideOutputEnable, 4'h0);
    chk("midIrq", irqPin_n, 4'h1);
    @(posedge clk) reset_n <= 1'h1;
    w(4);
    chk("midCtrl", highSideControlReg, 4'h0);
    chk("midOff", highSideOutputEnable, 4'h0);
    chk("midIsr", interruptSourceReg, 4'h0);
    complete_run();
  end
  initial begin
    w(3000);
    n_fail++;
    complete_run();
  end
endmodule // hsw_switch_ctrl_test
